/* File: hw/rfa_field_cell.sv */
/*
 One register field bit with a selectable access kind.
 Assumes read and write strobes are single-cycle pulses from the host
 access path and that the source condition is already in this clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module rfa_field_cell
   import rfa_pkg::*;
#(
   parameter logic [3:0] KIND       = 4'h0,
   parameter logic       RESET_VAL  = 1'b0,
   parameter logic       SOFT_IMMUNE = 1'b0
) (
   input  wire logic clk_sys_in,
   input  wire logic reset_in,
   input  wire logic soft_reset_in,
   input  wire logic host_rd_in,
   input  wire logic host_wr_in,
   input  wire logic wr_data_in,
   input  wire logic cond_in,
   output var  logic value_out
);

   logic bit_reg;
   logic bit_next;
   logic soft_hit;

   // Immune bits only answer the hard reset
   assign soft_hit = soft_reset_in && !SOFT_IMMUNE; // R6

   // Next value per kind; events win over clears
   always_comb begin
      bit_next = bit_reg;
      unique case (KIND)
         RFA_KIND_RW,
         RFA_KIND_WO: begin
            if (host_wr_in) begin // R8 R13
               bit_next = wr_data_in;
            end
         end
         RFA_KIND_RO: begin
            bit_next = cond_in; // R10
         end
         RFA_KIND_W1C: begin
            if (host_wr_in && wr_data_in) begin
               bit_next = 1'b0; // R11
            end
            if (cond_in) begin
               bit_next = 1'b1;
            end
         end
         RFA_KIND_WAC: begin
            if (host_wr_in) begin
               bit_next = 1'b0; // R9
            end
            if (cond_in) begin
               bit_next = 1'b1;
            end
         end
         RFA_KIND_RC,
         RFA_KIND_LH: begin
            if (host_rd_in) begin
               bit_next = 1'b0; // R12 R2
            end
            if (cond_in) begin
               bit_next = 1'b1;
            end
         end
         RFA_KIND_LL: begin
            if (host_rd_in) begin
               bit_next = 1'b1; // R1
            end
            if (!cond_in) begin
               bit_next = 1'b0;
            end
         end
         RFA_KIND_SC: begin
            // Write of one triggers; drops the cycle after
            bit_next = host_wr_in && wr_data_in; // R3
         end
         RFA_KIND_SS: begin
            bit_next = !(host_wr_in && !wr_data_in); // R4
         end
         RFA_KIND_STICKY: begin
            // Read re-arms from the live condition
            if (host_rd_in) begin
               bit_next = cond_in; // R5
            end else if (cond_in) begin
               bit_next = 1'b1;
            end
         end
         RFA_KIND_RSVD: begin
            bit_next = 1'b0; // R7
         end
         default: begin
            bit_next = bit_reg;
         end
      endcase
   end

   // Storage with hard and soft reset
   always_ff @(posedge clk_sys_in) begin
      if (reset_in || soft_hit) begin
         bit_reg <= RESET_VAL;
      end else begin
         bit_reg <= bit_next;
      end
   end

   // Write-only and reserved bits read as zero
   assign value_out = (KIND == RFA_KIND_WO || KIND == RFA_KIND_RSVD) ? 1'b0 : bit_reg;

endmodule : rfa_field_cell

`default_nettype wire

/* File: hw/rfa_pkg.sv */
/*
 Package for the register field access library: field kinds, widths and
 reset values shared by the field bank and its per-field cell.
 Assumes a single system clock and a synchronous active-high reset.
*/
package rfa_pkg;

   // Field attribute kinds, one code per behaviour
   typedef enum logic [3:0] {
      RFA_KIND_RW       = 4'h0,  // Plain read-write
      RFA_KIND_RO       = 4'h1,  // Read only, driven by logic
      RFA_KIND_WO       = 4'h2,  // Write only, reads as zero
      RFA_KIND_W1C      = 4'h3,  // Write one to clear
      RFA_KIND_WAC      = 4'h4,  // Write anything to clear
      RFA_KIND_RC       = 4'h5,  // Read to clear
      RFA_KIND_LL       = 4'h6,  // Latch low, clear on read
      RFA_KIND_LH       = 4'h7,  // Latch high, clear on read
      RFA_KIND_SC       = 4'h8,  // Self-clearing
      RFA_KIND_SS       = 4'h9,  // Self-setting
      RFA_KIND_STICKY   = 4'ha,  // Sticky high read only
      RFA_KIND_RSVD     = 4'hb   // Reserved
   } rfa_kind_e;

   // Bank shape: one 16-bit register of sixteen 1-bit fields
   localparam int unsigned RFA_WIDTH = 16;

   // Layout of the bank, bit by bit
   localparam logic [3:0] RFA_LAYOUT [RFA_WIDTH] = '{
      4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
      4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hb, 4'h0, 4'h3};

   // Bits kept through a software reset
   localparam logic [RFA_WIDTH-1:0] RFA_SOFT_IMMUNE = 16'hc001;

   // Reset values; latch-low and self-setting idle high
   localparam logic [RFA_WIDTH-1:0] RFA_RESET_VAL = 16'h0480;

endpackage : rfa_pkg

/* File: hw/rfa_field_bank.sv */
/*
 A 16-bit register built from field cells of mixed access kinds.
 Assumes the host access path gives one-cycle read and write strobes
 for this register; internal logic sees fields without side effects.
*/
`timescale 1ns/100ps
`default_nettype none

// Function
// R1: Latch-low bit catches a low and holds until the register is read.
// R2: Latch-high bit catches a high and holds until the register is read.
// R3: Self-clearing bit returns to zero itself; zero writes ignored.
// R4: Self-setting bit returns to one itself; one writes ignored.
// R5: Sticky bit holds high until read, then follows the condition.
// R6: Soft-reset-immune bits keep value on software reset.
// R7: Host writes zeros to reserved bits; reads of them undefined.
// R8: Read-write field stores writes and returns the stored value.
// R9: Write-anything-clear field reads back and clears on any write.
// R10: Read-only field ignores writes and follows internal logic.
// R11: Write-one-clear clears bits written one, keeps bits written zero.
// R12: Read-clear field returns contents then clears; writes ignored.
// R13: Write-only field reads unspecified; nothing relies on its reads.
// R14: Attributes act per field; clear-on-read only on host reads.
module rfa_field_bank
   import rfa_pkg::*;
(
   input  wire logic                 clk_sys_in,
   input  wire logic                 reset_in,
   input  wire logic                 soft_reset_in,
   input  wire logic                 host_rd_in,
   input  wire logic                 host_wr_in,
   input  wire logic [RFA_WIDTH-1:0] wr_data_in,
   input  wire logic [RFA_WIDTH-1:0] cond_in,
   output var  logic [RFA_WIDTH-1:0] rd_data_out,
   output var  logic [RFA_WIDTH-1:0] field_out
);

   logic [RFA_WIDTH-1:0] value;

   // One cell per bit, each with its own kind
   generate
      for (genvar i = 0; i < RFA_WIDTH; i++) begin : g_cell
         rfa_field_cell #(
            .KIND        (RFA_LAYOUT[i]),
            .RESET_VAL   (RFA_RESET_VAL[i]),
            .SOFT_IMMUNE (RFA_SOFT_IMMUNE[i])
         ) u_cell (
            .clk_sys_in    (clk_sys_in),
            .reset_in      (reset_in),
            .soft_reset_in (soft_reset_in),
            .host_rd_in    (host_rd_in), // R14
            .host_wr_in    (host_wr_in),
            .wr_data_in    (wr_data_in[i]),
            .cond_in       (cond_in[i]),
            .value_out     (value[i])
         );
      end
   endgenerate

   // Read data registered; shows value before the read's clear
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         rd_data_out <= '0;
      end else if (host_rd_in) begin
         rd_data_out <= value; // R12
      end
   end

   // Internal view has no side effects
   assign field_out = value; // R14

endmodule : rfa_field_bank

`default_nettype wire

/* File: tb/rfa_checker.sv */
/* Port checker for the field bank.
 Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module rfa_checker
   import rfa_pkg::*;
(
   input wire logic                 clk_sys_in,
   input wire logic                 reset_in,
   input wire logic                 soft_reset_in,
   input wire logic                 host_rd_in,
   input wire logic                 host_wr_in,
   input wire logic [RFA_WIDTH-1:0] wr_data_in,
   input wire logic [RFA_WIDTH-1:0] cond_in,
   input wire logic [RFA_WIDTH-1:0] rd_data_out,
   input wire logic [RFA_WIDTH-1:0] field_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   // Self-clearing bit stands one cycle only
   sequence one_pulse_s; field_out[9] ##1 !field_out[9]; endsequence
   self_clr_a: assert property (host_wr_in && wr_data_in[9] && !soft_reset_in ##1 !host_wr_in
      |-> one_pulse_s) else $error("self clear bit stuck");
   self_set_a: assert property (!field_out[10] && !(host_wr_in && !wr_data_in[10])
      |=> field_out[10]) else $error("self set bit stuck");
   rw_store_a: assert property (host_wr_in && !soft_reset_in
      |=> field_out[1:0] == $past(wr_data_in[1:0])) else $error("rw not stored");
   any_wr_clr_a: assert property (host_wr_in && !cond_in[5] |=> !field_out[5])
      else $error("write did not clear");
   one_wr_clr_a: assert property (host_wr_in && wr_data_in[15] && !cond_in[15]
      |=> !field_out[15]) else $error("one write did not clear");
   low_latch_a: assert property (!field_out[7] && !host_rd_in && !soft_reset_in
      |=> !field_out[7]) else $error("low latch lost");
   high_latch_a: assert property (field_out[8] && !host_rd_in && !soft_reset_in
      |=> field_out[8]) else $error("high latch lost");
   sticky_read_a: assert property (host_rd_in && !soft_reset_in
      |=> field_out[11] == $past(cond_in[11])) else $error("sticky after read");
   rd_capture_a: assert property (host_rd_in
      |=> rd_data_out[1:0] == $past(field_out[1:0])) else $error("read data wrong");
endmodule : rfa_checker
bind rfa_field_bank rfa_checker chk_i (.clk_sys_in, .reset_in, .soft_reset_in, .host_rd_in,
   .host_wr_in, .wr_data_in, .cond_in, .rd_data_out, .field_out);
`default_nettype wire

/* File: tb/tb_rfa_field_bank.sv */
/* Self-checking bench for the field bank.
 Drives ports at the falling edge; checker is bound in. */
`timescale 1ns/100ps
`default_nettype none
module tb_rfa_field_bank;
   import rfa_pkg::*;
   logic        clk_sys_in, reset_in, soft_reset_in, host_rd_in, host_wr_in, rd_seen;
   logic [15:0] wr_data_in, cond_in, rd_data_out, w, exp_q[$];
   int          fails, checked, seed = 32'h9de3;
   rfa_field_bank dut (.clk_sys_in, .reset_in, .soft_reset_in, .host_rd_in, .host_wr_in,
      .wr_data_in, .cond_in, .rd_data_out, .field_out());
   task chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task final_report;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   task wr(input logic [15:0] d);
      @(negedge clk_sys_in) {host_wr_in, wr_data_in} = {1'b1, d};
      @(negedge clk_sys_in) host_wr_in = 1'b0;
   endtask : wr
   // Read spaced by two idle cycles so pulse bits settle
   task rd(input logic [15:0] e);
      @(negedge clk_sys_in) host_rd_in = 1'b1;
      exp_q.push_back(e);
      @(negedge clk_sys_in) host_rd_in = 1'b0;
      @(negedge clk_sys_in);
   endtask : rd
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   // Monitor: read data stands from the edge after the strobe
   always @(posedge clk_sys_in) begin
      rd_seen <= host_rd_in;
      if (rd_seen) chk(rd_data_out, exp_q.pop_front());
   end
   initial begin
      #200us fails++;
      final_report;
   end
   initial begin
      {reset_in, soft_reset_in, host_rd_in, host_wr_in} = 4'h8;
      {wr_data_in, cond_in} = {16'h0, 16'h0080}; // Low-latch source idles high
      repeat (3) @(negedge clk_sys_in);
      reset_in = 1'b0;
      rd(16'h0480);
      repeat (6) begin
         w = 16'($random(seed));
         wr((w & 16'hcfff) | 16'h0400);
         rd((w & 16'h4003) | 16'h0480);
      end
      wr(16'h0600);
      wr(16'h0000);
      @(negedge clk_sys_in) cond_in = 16'h0970; // Events plus a low dip
      @(negedge clk_sys_in) cond_in = 16'h0080;
      rd(16'h0d70);
      rd(16'h04b0);
      wr(16'h8410);
      rd(16'h0480);
      @(negedge clk_sys_in) cond_in = 16'h0880;
      @(negedge clk_sys_in) cond_in = 16'h0080;
      rd(16'h0c80);
      rd(16'h0480);
      wr(16'h4003);
      @(negedge clk_sys_in) soft_reset_in = 1'b1;
      @(negedge clk_sys_in) soft_reset_in = 1'b0;
      rd(16'h4481);
      // Clear event pulses one cycle; read-only and sticky sources stay up over a read
      @(negedge clk_sys_in) cond_in = 16'h8884;
      @(negedge clk_sys_in) cond_in = 16'h0884;
      wr(16'h0000);
      rd(16'h8c84);
      wr(16'h8000);
      rd(16'h0c84);
      repeat (3) @(negedge clk_sys_in);
      final_report;
   end
endmodule : tb_rfa_field_bank
`default_nettype wire
